// >>> common/rrs_pkg.sv
package rrs_pkg;
	// ==========================================================
	// timing
	// ==========================================================
	localparam int CLK_HZ = 50_000_000;          // mclk rate
	localparam int START_MIN_US = 500;           // least start pulse width, us
	localparam int CLOSURE_MS = 120;             // isolated contact closure, ms
	// least time in whole cycles; the per-us factor is an integer division, which rounds down
	localparam int START_MIN_CYC = (START_MIN_US * (CLK_HZ / 1_000_000));
	localparam int CLOSURE_CYC = (CLOSURE_MS * (CLK_HZ / 1_000));
	localparam int MAX_PARTIES = 10;             // bus population limit
	localparam int CNT_W = 24;                   // wide enough for closure count
	// ==========================================================
	// run states
	// ==========================================================
	typedef enum logic [1:0] {
		RRS_IDLE,
		RRS_PREP,
		RRS_RUN
	} rrs_state_t;
endpackage : rrs_pkg

// >>> common/rrs_line_if.sv
`timescale 1ns/100ps
// one open-drain bus line, as seen from the qualifier
interface rrs_line_if;
	logic raw;          // pin level, unsynchronised
	logic low_seen;     // synchronised line is low
	logic qualified;    // low for the qualifying width
	modport qual (input raw, output low_seen, output qualified);
	modport user (output raw, input low_seen, input qualified);
endinterface : rrs_line_if

// >>> design/rrs_line_qual.sv
`timescale 1ns/100ps
// ==========================================================
// two-flop synchroniser plus low-width qualifier
// ==========================================================
module rrs_line_qual #(
	parameter int MIN_CYC = 1
) (
	input wire logic mclk,
	input wire logic reset,
	rrs_line_if.qual line
);
	import rrs_pkg::*;
	logic meta_ff;                 // first stage, read only by sync_ff
	logic sync_ff;                 // second stage
	logic [CNT_W-1:0] low_cnt_ff;  // cycles the line has stayed low
	logic [CNT_W-1:0] nxt_low_cnt;
	logic at_min;
	localparam logic [CNT_W-1:0] MIN_V = CNT_W'(MIN_CYC);

	// ==========================================================
	// synchroniser
	// ==========================================================
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= line.raw;
			sync_ff <= meta_ff;
		end
	end

	// counter saturates so a long low stays qualified
	assign at_min = (low_cnt_ff >= MIN_V);
	assign nxt_low_cnt = sync_ff ? '0 : (at_min ? low_cnt_ff : low_cnt_ff + 1'b1);

	// width counter
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			low_cnt_ff <= '0;
		end else begin
			low_cnt_ff <= nxt_low_cnt;
		end
	end

	assign line.low_seen = ~sync_ff;
	assign line.qualified = at_min;
endmodule : rrs_line_qual

// >>> design/rrs_top.sv
`timescale 1ns/100ps
module rrs_top (
	input wire logic mclk,
	input wire logic reset,
	input wire logic prep_in,        // prepare pin level
	output logic prep_oe_n,          // low: pull prepare low
	input wire logic ready_in,       // ready pin level
	output logic ready_oe_n,         // low: pull ready low (not ready)
	input wire logic start_in,       // start pin level
	output logic start_oe_n,         // low: pull start low
	input wire logic stop_in,        // stop pin level
	output logic stop_oe_n,          // low: pull stop low
	output logic contact_closed,     // isolated start contact drive
	input wire logic local_ready,    // this instrument is ready
	input wire logic local_prep,     // one-cycle local prepare request
	input wire logic local_start,    // one-cycle local start request
	input wire logic local_stop,     // one-cycle local stop request
	input wire logic run_done,       // one-cycle: run finished by itself
	output rrs_pkg::rrs_state_t run_state,  // current run state
	output logic sys_ready           // synchronised bus ready
);
	import rrs_pkg::*;

	// ==========================================================
	// line qualifiers
	// ==========================================================
	rrs_line_if prep_l ();
	rrs_line_if start_l ();
	rrs_line_if stop_l ();
	rrs_line_if ready_l ();
	assign prep_l.raw = prep_in;
	assign start_l.raw = start_in;
	assign stop_l.raw = stop_in;
	assign ready_l.raw = ready_in;

	rrs_line_qual #(.MIN_CYC(1)) u_prep (.mclk(mclk), .reset(reset), .line(prep_l));
	rrs_line_qual #(.MIN_CYC(START_MIN_CYC)) u_start (.mclk(mclk), .reset(reset),
		.line(start_l));
	rrs_line_qual #(.MIN_CYC(1)) u_stop (.mclk(mclk), .reset(reset), .line(stop_l));
	rrs_line_qual #(.MIN_CYC(1)) u_ready (.mclk(mclk), .reset(reset), .line(ready_l));

	// ==========================================================
	// state and timers
	// ==========================================================
	rrs_state_t state_ff;             // run state
	rrs_state_t nxt_state;
	logic start_q_ff;                 // qualified start, last cycle
	logic [CNT_W-1:0] closure_ff;     // contact closure remaining
	logic [CNT_W-1:0] nxt_closure;
	logic [CNT_W-1:0] start_drv_ff;   // own start pulse remaining
	logic [CNT_W-1:0] prep_drv_ff;    // own prepare pulse remaining
	logic [CNT_W-1:0] stop_drv_ff;    // own stop pulse remaining
	logic start_evt;                  // run begins this cycle
	logic stop_evt;                   // run ends this cycle
	logic prep_evt;                   // preparation begins
	localparam logic [CNT_W-1:0] PULSE_V = CNT_W'(START_MIN_CYC);
	localparam logic [CNT_W-1:0] CLOS_V = CNT_W'(CLOSURE_CYC);

	// a qualified start acts once, on its rising qualification
	assign start_evt = (start_l.qualified & ~start_q_ff) | local_start;
	// stop wins over start and prepare in every state and blocks own start drive and contact: the device must reach ready quickly
	assign stop_evt = stop_l.low_seen | local_stop | run_done;
	assign prep_evt = prep_l.low_seen | local_prep;

	// next run state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RRS_IDLE: begin
				if (stop_evt) begin
					nxt_state = RRS_IDLE;
				end else if (start_evt) begin
					nxt_state = RRS_RUN;
				end else if (prep_evt) begin
					nxt_state = RRS_PREP;
				end
			end
			RRS_PREP: begin
				if (stop_evt) begin
					nxt_state = RRS_IDLE;
				end else if (start_evt) begin
					nxt_state = RRS_RUN;
				end
			end
			RRS_RUN: begin
				if (stop_evt) begin
					nxt_state = RRS_IDLE;
				end
			end
			default: begin
				nxt_state = RRS_IDLE;
			end
		endcase
	end

	// closure reloads on every run start
	assign nxt_closure = (start_evt && !stop_evt) ? CLOS_V
		: ((closure_ff != '0) ? closure_ff - 1'b1 : closure_ff);

	// count down helper for own drive pulses
	function automatic logic [CNT_W-1:0] dec_or_load(input logic load,
		input logic [CNT_W-1:0] cur);
		if (load) begin
			dec_or_load = PULSE_V;
		end else if (cur != '0) begin
			dec_or_load = cur - 1'b1;
		end else begin
			dec_or_load = cur;
		end
	endfunction : dec_or_load

	// state register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_ff <= RRS_IDLE;
			start_q_ff <= 1'b0;
			closure_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			start_q_ff <= start_l.qualified;
			closure_ff <= nxt_closure;
		end
	end

	// own bus pulses: local actions are held low the minimum width
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			start_drv_ff <= '0;
			prep_drv_ff <= '0;
			stop_drv_ff <= '0;
		end else begin
			start_drv_ff <= dec_or_load(local_start & ~stop_evt, start_drv_ff);
			prep_drv_ff <= dec_or_load(local_prep, prep_drv_ff);
			stop_drv_ff <= dec_or_load(local_stop, stop_drv_ff);
		end
	end

	// ==========================================================
	// pin drive: enable low means pull low, never drive high
	// ==========================================================
	// sinking only keeps a bus of up to ten parties free of contention
	assign start_oe_n = (start_drv_ff == '0);
	assign prep_oe_n = (prep_drv_ff == '0);
	assign stop_oe_n = (stop_drv_ff == '0);
	assign ready_oe_n = local_ready;
	assign contact_closed = (closure_ff != '0);
	assign run_state = state_ff;
	assign sys_ready = ~ready_l.low_seen;

	// ==========================================================
	// checks
	// ==========================================================
	a_stop_to_idle: assert property (@(posedge mclk) disable iff (reset)
		stop_evt |=> state_ff == RRS_IDLE) else $error("stop did not return to idle");
	a_start_to_run: assert property (@(posedge mclk) disable iff (reset)
		(start_evt && !stop_evt) |=> state_ff == RRS_RUN) else $error("start not taken");
	a_prep_entry: assert property (@(posedge mclk) disable iff (reset)
		(state_ff == RRS_IDLE && prep_evt && !start_evt && !stop_evt) |=> state_ff == RRS_PREP)
		else $error("prepare not taken");
	sequence s_start_go;
		start_evt && !stop_evt;
	endsequence
	a_contact_len: assert property (@(posedge mclk) disable iff (reset)
		s_start_go |=> (closure_ff == CLOS_V) && contact_closed) else $error("closure length");
	a_contact_ends: assert property (@(posedge mclk) disable iff (reset)
		(closure_ff == 24'h000001 && !start_evt) |=> !contact_closed) else $error("closure stuck");
	a_start_drive: assert property (@(posedge mclk) disable iff (reset)
		(local_start && !stop_evt) |=> !start_oe_n [*8]) else $error("start pulse short");
	a_prep_drive: assert property (@(posedge mclk) disable iff (reset)
		local_prep |=> !prep_oe_n [*8]) else $error("prepare pulse short");
	a_ready_pass: assert property (@(posedge mclk) disable iff (reset)
		!local_ready |-> !ready_oe_n) else $error("ready not pulled low");
	a_no_short_start: assert property (@(posedge mclk) disable iff (reset)
		(start_l.qualified && !start_q_ff) |-> $past(start_l.low_seen, 2))
		else $error("short start accepted");
endmodule : rrs_top

// >>> test/rrs_far_party.sv
`timescale 1ns/100ps
// ==========================================
// another instrument on the shared bus
// ==========================================
module rrs_far_party (
	input wire logic mclk,
	output logic prep_pull_n,  // low: pulls prepare line
	output logic start_pull_n, // low: pulls start line
	output logic stop_pull_n,  // left open unless told
	output logic rdy_pull_n    // low: this party not ready
);
	// open-collector idles released, the pull-up wins
	initial begin
		prep_pull_n = 1'h1;
		start_pull_n = 1'h1;
		stop_pull_n = 1'h1;
		rdy_pull_n = 1'h1;
	end
	// hold one line low for cyc clocks, then let go
	task automatic pull(input int line, input int cyc);
		@(posedge mclk);
		#2;
		prep_pull_n = (line != 0);
		start_pull_n = (line != 1);
		stop_pull_n = (line != 2);
		repeat (cyc) @(posedge mclk);
		#2;
		prep_pull_n = 1'h1;
		start_pull_n = 1'h1;
		stop_pull_n = 1'h1;
	endtask : pull
	// ready status, high true
	task automatic set_rdy(input logic v);
		rdy_pull_n = v;
	endtask : set_rdy
endmodule : rrs_far_party

// >>> test/tb.sv
`timescale 1ns/100ps
// ==========================================
// bench top
// ==========================================
module tb;
	import rrs_pkg::*;
	typedef struct {int line; int width; rrs_state_t st;} rrs_row_t;
	logic mclk, reset, local_ready, local_prep, local_start, local_stop, run_done;
	logic prep_oe_n, ready_oe_n, start_oe_n, stop_oe_n, contact_closed, sys_ready;
	logic p_prep_n, p_start_n, p_stop_n, p_rdy_n; // far side pulls
	rrs_state_t run_state;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	// wired-and of every party, pull-up when all let go
	wire prep_w = prep_oe_n & p_prep_n;
	wire start_w = start_oe_n & p_start_n;
	wire stop_w = stop_oe_n & p_stop_n;
	wire ready_w = ready_oe_n & p_rdy_n;
	// bus rows: line 0 prepare, 1 start, 2 stop; short start must be ignored
	rrs_row_t rows [5] = '{'{0, 10, RRS_PREP}, '{2, 10, RRS_IDLE},
		'{1, 1000, RRS_IDLE}, '{1, START_MIN_CYC + 10, RRS_RUN}, '{2, 10, RRS_IDLE}};
	rrs_top DUT (.mclk(mclk), .reset(reset), .prep_in(prep_w), .prep_oe_n(prep_oe_n),
		.ready_in(ready_w), .ready_oe_n(ready_oe_n), .start_in(start_w),
		.start_oe_n(start_oe_n), .stop_in(stop_w), .stop_oe_n(stop_oe_n),
		.contact_closed(contact_closed), .local_ready(local_ready), .local_prep(local_prep),
		.local_start(local_start), .local_stop(local_stop), .run_done(run_done),
		.run_state(run_state), .sys_ready(sys_ready));
	rrs_far_party P (.mclk(mclk), .prep_pull_n(p_prep_n), .start_pull_n(p_start_n),
		.stop_pull_n(p_stop_n), .rdy_pull_n(p_rdy_n));
	// ==========================================
	// clock and hang guard
	// ==========================================
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	// whole run is about 80000 cycles; a hang beyond that is a failure
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			conclude();
		end
	end
	// ==========================================
	// compare and report tasks
	// ==========================================
	task automatic chk_bit(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic chk_state(input string nm, input rrs_state_t e, input rrs_state_t g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_state
	task automatic chk_cnt(input string nm, input int e, input int g);
		comparisons++;
		if (g != e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_cnt
	// step a few clocks, settled just after the edge
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask : tick
	// count how long an own pulse holds its line low
	task automatic low_len(ref logic oe);
		n = 0;
		while (oe !== 1'h0 && n < 10) begin
			n++;
			tick(1);
		end
		n = 0;
		while (oe === 1'h0 && n < 30000) begin
			n++;
			tick(1);
		end
	endtask : low_len
	task automatic conclude();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	// ==========================================
	// main sequence
	// ==========================================
	initial begin
		reset = 1'h1;
		{local_prep, local_start, local_stop, run_done} = 4'h0;
		local_ready = 1'h1;
		tick(8);
		reset = 1'h0;
		tick(2);
		chk_state("reset state", RRS_IDLE, run_state);
		chk_bit("idle start", 1'h1, start_oe_n);
		chk_bit("idle contact", 1'h0, contact_closed);
		chk_bit("idle ready", 1'h1, sys_ready);
		local_ready = 1'h0;
		tick(4);
		chk_bit("ready pull", 1'h0, ready_oe_n);
		chk_bit("ready low", 1'h0, sys_ready);
		local_ready = 1'h1;
		P.set_rdy(1'h0);
		tick(4);
		chk_bit("far not ready", 1'h0, sys_ready);
		P.set_rdy(1'h1);
		tick(4);
		chk_bit("ready back", 1'h1, sys_ready);
		$display("test ready done");
		// bus stimulus table
		foreach (rows[i]) begin
			P.pull(rows[i].line, rows[i].width);
			tick(4);
			chk_state("bus row", rows[i].st, run_state);
			if (rows[i].st == RRS_RUN)
				chk_bit("contact on", 1'h1, contact_closed);
		end
		$display("test bus rows done");
		// local start goes onto the bus for the least width; the line drops at the
		// edge that takes the request, so counting starts right after that edge
		local_start = 1'h1;
		tick(1);
		local_start = 1'h0;
		chk_state("local start", RRS_RUN, run_state);
		chk_bit("contact local", 1'h1, contact_closed);
		low_len(start_oe_n);
		chk_cnt("start width", START_MIN_CYC, n);
		tick(10);
		chk_bit("contact held", 1'h1, contact_closed);
		$display("test local start done");
		// local stop from a run, also propagated
		local_stop = 1'h1;
		tick(1);
		local_stop = 1'h0;
		chk_state("local stop", RRS_IDLE, run_state);
		low_len(stop_oe_n);
		chk_cnt("stop width", START_MIN_CYC, n);
		$display("test local stop done");
		tick(4);
		local_prep = 1'h1;
		tick(1);
		local_prep = 1'h0;
		tick(2);
		chk_bit("prep pull", 1'h0, prep_oe_n);
		chk_state("local prep", RRS_PREP, run_state);
		$display("test local prep done");
		// start and stop in one cycle: stop wins and no start reaches the bus
		local_start = 1'h1;
		local_stop = 1'h1;
		tick(1);
		{local_start, local_stop} = 2'h0;
		chk_state("stop over start", RRS_IDLE, run_state);
		chk_bit("no start drive", 1'h1, start_oe_n);
		chk_bit("stop drive", 1'h0, stop_oe_n);
		$display("test stop over start done");
		// reset while idle, with own stop and prepare pulses and the contact still on, drops them all at once
		reset = 1'h1;
		tick(1);
		chk_state("mid reset state", RRS_IDLE, run_state);
		chk_bit("mid reset stop", 1'h1, stop_oe_n);
		chk_bit("mid reset prep", 1'h1, prep_oe_n);
		chk_bit("mid reset contact", 1'h0, contact_closed);
		reset = 1'h0;
		tick(2);
		chk_bit("after reset ready", 1'h1, sys_ready);
		chk_state("after reset state", RRS_IDLE, run_state);
		$display("test mid reset done");
		// a run that finishes by itself returns to idle like a stop
		local_start = 1'h1;
		tick(1);
		local_start = 1'h0;
		chk_state("second start", RRS_RUN, run_state);
		run_done = 1'h1;
		tick(1);
		run_done = 1'h0;
		chk_state("run done", RRS_IDLE, run_state);
		chk_bit("start still driven", 1'h0, start_oe_n);
		$display("test run done done");
		conclude();
	end
endmodule : tb
